// ==== pie_top.sv ====
/*
  pie_top: input-enable registers for ports C, D and E behind an APB slave,
  plus the gated pin input path of each port.
  Assumes one clock, a synchronous active-high reset and pins that are
  asynchronous to the clock.
*/
//
// Contract
// - port C enable register at index 30BA
// - port C bits read/write, 1 enables input
// - port D enable register at index 30BB
// - port D bits read/write, 1 enables input
// - port E enable register at index 30BC
// - port E bits read/write, 1 enables input
`timescale 1ns/1ps
`default_nettype none

module pie_top
  import pie_pkg::*;
(
  input  wire logic                  mclk_in,
  input  wire logic                  rst_in,
  input  wire pie_apb_req_t          apb_req_in,
  output var  pie_apb_rsp_t          apb_rsp_out,
  input  wire logic [PIE_PORT_W-1:0] port_c_pins_in,
  input  wire logic [PIE_PORT_W-1:0] port_d_pins_in,
  input  wire logic [PIE_PORT_W-1:0] port_e_pins_in,
  output var  logic [PIE_PORT_W-1:0] port_c_in_en_out,
  output var  logic [PIE_PORT_W-1:0] port_d_in_en_out,
  output var  logic [PIE_PORT_W-1:0] port_e_in_en_out,
  output var  logic [PIE_PORT_W-1:0] port_c_level_out,
  output var  logic [PIE_PORT_W-1:0] port_d_level_out,
  output var  logic [PIE_PORT_W-1:0] port_e_level_out
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic [13:0] idx;
  logic        aligned;
  logic        hit_pc_ie;
  logic        hit_pd_ie;
  logic        hit_pe_ie;
  logic        hit_pc_lvl;
  logic        hit_pd_lvl;
  logic        hit_pe_lvl;
  logic        mapped;
  logic        setup;
  logic        access;
  logic        wr_byte;

  assign idx        = apb_req_in.paddr[PIE_ADDR_W-1:2];
  assign aligned    = (apb_req_in.paddr[1:0] == 2'h0);
  assign hit_pc_ie  = aligned && (idx == PIE_IDX_PC_IE);
  assign hit_pd_ie  = aligned && (idx == PIE_IDX_PD_IE);
  assign hit_pe_ie  = aligned && (idx == PIE_IDX_PE_IE);
  assign hit_pc_lvl = aligned && (idx == PIE_IDX_PC_LVL);
  assign hit_pd_lvl = aligned && (idx == PIE_IDX_PD_LVL);
  assign hit_pe_lvl = aligned && (idx == PIE_IDX_PE_LVL);
  assign mapped     = hit_pc_ie || hit_pd_ie || hit_pe_ie ||
                      hit_pc_lvl || hit_pd_lvl || hit_pe_lvl;

  assign setup   = apb_req_in.psel && !apb_req_in.penable;
  assign access  = apb_req_in.psel && apb_req_in.penable;
  // only byte lane 0 carries register data; other lanes are ignored
  assign wr_byte = access && apb_req_in.pwrite && apb_req_in.pstrb[0];

  // ----------------------------------------------------------------
  // enable registers
  // ----------------------------------------------------------------
  pie_en_reg u_reg_c (
    .mclk_in  (mclk_in),
    .rst_in   (rst_in),
    .wr_in    (wr_byte && hit_pc_ie),
    .wdata_in (apb_req_in.pwdata[PIE_PORT_W-1:0]),
    .q_out    (port_c_in_en_out)
  );

  pie_en_reg u_reg_d (
    .mclk_in  (mclk_in),
    .rst_in   (rst_in),
    .wr_in    (wr_byte && hit_pd_ie),
    .wdata_in (apb_req_in.pwdata[PIE_PORT_W-1:0]),
    .q_out    (port_d_in_en_out)
  );

  pie_en_reg u_reg_e (
    .mclk_in  (mclk_in),
    .rst_in   (rst_in),
    .wr_in    (wr_byte && hit_pe_ie),
    .wdata_in (apb_req_in.pwdata[PIE_PORT_W-1:0]),
    .q_out    (port_e_in_en_out)
  );

  // ----------------------------------------------------------------
  // gated pin input paths
  // ----------------------------------------------------------------
  pie_pin_sync u_sync_c (
    .mclk_in   (mclk_in),
    .rst_in    (rst_in),
    .pins_in   (port_c_pins_in),
    .in_en_in  (port_c_in_en_out),
    .level_out (port_c_level_out)
  );

  pie_pin_sync u_sync_d (
    .mclk_in   (mclk_in),
    .rst_in    (rst_in),
    .pins_in   (port_d_pins_in),
    .in_en_in  (port_d_in_en_out),
    .level_out (port_d_level_out)
  );

  pie_pin_sync u_sync_e (
    .mclk_in   (mclk_in),
    .rst_in    (rst_in),
    .pins_in   (port_e_pins_in),
    .in_en_in  (port_e_in_en_out),
    .level_out (port_e_level_out)
  );

  // ----------------------------------------------------------------
  // read data and error, captured in the setup cycle
  // ----------------------------------------------------------------
  // capturing at setup keeps prdata on a flop yet costs no wait state
  logic [31:0] next_rdata;
  logic [31:0] rdata;
  logic        slverr;

  always_comb begin
    next_rdata = PIE_RD_RESET;
    if (hit_pc_ie) begin
      next_rdata[PIE_PORT_W-1:0] = port_c_in_en_out;
    end else if (hit_pd_ie) begin
      next_rdata[PIE_PORT_W-1:0] = port_d_in_en_out;
    end else if (hit_pe_ie) begin
      next_rdata[PIE_PORT_W-1:0] = port_e_in_en_out;
    end else if (hit_pc_lvl) begin
      next_rdata[PIE_PORT_W-1:0] = port_c_level_out;
    end else if (hit_pd_lvl) begin
      next_rdata[PIE_PORT_W-1:0] = port_d_level_out;
    end else if (hit_pe_lvl) begin
      next_rdata[PIE_PORT_W-1:0] = port_e_level_out;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      rdata <= PIE_RD_RESET;
    end else if (setup && !apb_req_in.pwrite) begin
      rdata <= next_rdata;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      slverr <= 1'b0;
    end else if (setup) begin
      slverr <= !mapped;
    end
  end

  always_comb begin
    apb_rsp_out.prdata  = rdata;
    apb_rsp_out.pready  = access;
    apb_rsp_out.pslverr = access && slverr;
  end

endmodule

`default_nettype wire

// ==== pie_pkg.sv ====
/*
  pie_pkg: constants and carrier types for the port input-enable block.
  Assumes a 32-bit APB slave port and byte-wide port registers.
*/
`default_nettype none

package pie_pkg;

  // ----------------------------------------------------------------
  // register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [13:0] PIE_IDX_PC_IE  = 14'h30BA;
  localparam logic [13:0] PIE_IDX_PD_IE  = 14'h30BB;
  localparam logic [13:0] PIE_IDX_PE_IE  = 14'h30BC;
  localparam logic [13:0] PIE_IDX_PC_LVL = 14'h30C0;
  localparam logic [13:0] PIE_IDX_PD_LVL = 14'h30C1;
  localparam logic [13:0] PIE_IDX_PE_LVL = 14'h30C2;

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int          PIE_ADDR_W    = 16;
  localparam int          PIE_PORT_W    = 8;
  localparam logic [7:0]  PIE_IE_RESET  = 8'h00;
  localparam logic [7:0]  PIE_PIN_RESET = 8'h00;
  localparam logic [31:0] PIE_RD_RESET  = 32'h0000_0000;

  typedef struct packed {
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [PIE_ADDR_W-1:0] paddr;
    logic [31:0]           pwdata;
    logic [3:0]            pstrb;
  } pie_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } pie_apb_rsp_t;

endpackage

`default_nettype wire

// ==== pie_en_reg.sv ====
/*
  pie_en_reg: one byte-wide read/write enable register.
  Assumes a one-cycle write strobe from the bus decoder on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module pie_en_reg
  import pie_pkg::*;
(
  input  wire logic                  mclk_in,
  input  wire logic                  rst_in,
  input  wire logic                  wr_in,
  input  wire logic [PIE_PORT_W-1:0] wdata_in,
  output var  logic [PIE_PORT_W-1:0] q_out
);

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      q_out <= PIE_IE_RESET;
    end else if (wr_in) begin
      q_out <= wdata_in;
    end
  end

endmodule

`default_nettype wire

// ==== pie_pin_sync.sv ====
/*
  pie_pin_sync: brings one port's pin levels into the clock domain and
  gates each bit with its input enable.
  Assumes the pins are asynchronous to mclk_in.
*/
`timescale 1ns/1ps
`default_nettype none

module pie_pin_sync
  import pie_pkg::*;
(
  input  wire logic                  mclk_in,
  input  wire logic                  rst_in,
  input  wire logic [PIE_PORT_W-1:0] pins_in,
  input  wire logic [PIE_PORT_W-1:0] in_en_in,
  output var  logic [PIE_PORT_W-1:0] level_out
);

  logic [PIE_PORT_W-1:0] meta;
  logic [PIE_PORT_W-1:0] stable;

  localparam logic [PIE_PORT_W-1:0] PIN_RESET_V = PIE_PIN_RESET;

  // ----------------------------------------------------------------
  // two-flop synchroniser, first stage read only by the second
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      meta   <= PIN_RESET_V;
      stable <= PIN_RESET_V;
    end else begin
      meta   <= pins_in;
      stable <= meta;
    end
  end

  // a disabled input reads as zero, so a floating pad never leaks in
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      level_out <= PIN_RESET_V;
    end else begin
      level_out <= stable & in_en_in;
    end
  end

endmodule

`default_nettype wire

// ==== pie_checker_properties.sv ====
/* pie_checker: port-level checks for pie_top.
   Assumes it is bound to pie_top and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module pie_checker
  import pie_pkg::*;
(
  input wire logic         mclk_in,
  input wire logic         rst_in,
  input wire pie_apb_req_t apb_req_in,
  input wire pie_apb_rsp_t apb_rsp_out,
  input wire logic [7:0]   port_c_in_en_out,
  input wire logic [7:0]   port_d_in_en_out,
  input wire logic [7:0]   port_e_in_en_out,
  input wire logic [7:0]   port_c_level_out
);
  localparam logic [15:0] ADR_C = {PIE_IDX_PC_IE, 2'b00};
  localparam logic [15:0] ADR_D = {PIE_IDX_PD_IE, 2'b00};
  localparam logic [15:0] ADR_E = {PIE_IDX_PE_IE, 2'b00};
  logic       acc;
  logic       wr;
  logic [7:0] wbyte;
  assign acc   = apb_req_in.psel & apb_req_in.penable;
  assign wr    = acc & apb_req_in.pwrite & apb_req_in.pstrb[0];
  assign wbyte = apb_req_in.pwdata[7:0];
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  ready_now_a: assert property (acc |-> apb_rsp_out.pready)
    else $error("pready missing in access phase");
  c_write_a: assert property (
    wr && apb_req_in.paddr == ADR_C |=> port_c_in_en_out == $past(wbyte))
    else $error("port C enable write lost");
  d_write_a: assert property (
    wr && apb_req_in.paddr == ADR_D |=> port_d_in_en_out == $past(wbyte))
    else $error("port D enable write lost");
  e_write_a: assert property (
    wr && apb_req_in.paddr == ADR_E |=> port_e_in_en_out == $past(wbyte))
    else $error("port E enable write lost");
  en_hold_a: assert property (
    !wr |=> $stable({port_c_in_en_out, port_d_in_en_out, port_e_in_en_out}))
    else $error("enable changed without a write");
  reset_clear_a: assert property (disable iff (1'b0)
    rst_in |=> {port_c_in_en_out, port_d_in_en_out, port_e_in_en_out} == 24'h000000)
    else $error("enables not cleared by reset");
  read_c_a: assert property (
    apb_req_in.psel && !apb_req_in.penable && !apb_req_in.pwrite && apb_req_in.paddr == ADR_C
    |=> apb_rsp_out.prdata == {24'h000000, $past(port_c_in_en_out)})
    else $error("port C read data wrong");
  // levels lag the enable by one edge, so compare against last cycle's enable
  gate_c_a: assert property ((port_c_level_out & ~$past(port_c_in_en_out)) == 8'h00)
    else $error("disabled port C pin passed its level");
  cover property (wr && apb_req_in.paddr == ADR_C);
  cover property (acc && !apb_req_in.pwrite && apb_req_in.paddr == ADR_E);
  cover property (acc && apb_rsp_out.pslverr);
endmodule
bind pie_top pie_checker u_chk (
  .mclk_in(mclk_in), .rst_in(rst_in), .apb_req_in(apb_req_in), .apb_rsp_out(apb_rsp_out),
  .port_c_in_en_out(port_c_in_en_out), .port_d_in_en_out(port_d_in_en_out),
  .port_e_in_en_out(port_e_in_en_out), .port_c_level_out(port_c_level_out));
`default_nettype wire

// ==== pie_top_test.sv ====
/* pie_top_test: self-checking bench for pie_top.
   Assumes the checker is bound in; a cycle ceiling cuts a hang short. */
`timescale 1ns/1ps
`default_nettype none
module pie_top_test
  import pie_pkg::*;
;
  localparam logic [15:0] AC = {PIE_IDX_PC_IE, 2'b00};
  localparam logic [15:0] AD = {PIE_IDX_PD_IE, 2'b00};
  localparam logic [15:0] AE = {PIE_IDX_PE_IE, 2'b00};
  logic         mclk_in;
  logic         rst_in;
  pie_apb_req_t req;
  pie_apb_rsp_t rsp;
  logic [7:0]   pc, pd, pe, ec, ed, ee, lc, ld, le;
  logic [31:0]  rd;
  logic         err;
  int           failures = 0;
  int           comparisons = 0;
  int           cycles = 0;
  logic [15:0]  row_a [6] = '{AC, AD, AE, AC, AD, AE};
  logic [31:0]  row_d [6] = '{32'hFFFFFF5A, 32'hA5, 32'h123456FF, 32'h0, 32'h3C, 32'h81};
  logic [31:0]  row_q [6] = '{32'h5A, 32'hA5, 32'hFF, 32'h0, 32'h3C, 32'h81};
  pie_top dut (.mclk_in(mclk_in), .rst_in(rst_in), .apb_req_in(req), .apb_rsp_out(rsp),
    .port_c_pins_in(pc), .port_d_pins_in(pd), .port_e_pins_in(pe),
    .port_c_in_en_out(ec), .port_d_in_en_out(ed), .port_e_in_en_out(ee),
    .port_c_level_out(lc), .port_d_level_out(ld), .port_e_level_out(le));
  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end
  task automatic complete_run;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      failures++;
      complete_run;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  // no wait-state count assumed: the access phase lasts until pready
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge mclk_in);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d, pstrb: s};
    @(posedge mclk_in);
    req.penable <= 1'b1;
    do @(posedge mclk_in); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    // one more edge so register outputs updated by the access have settled
    @(posedge mclk_in);
  endtask
  function automatic logic [7:0] en_of(input logic [15:0] a);
    return a == AC ? ec : (a == AD ? ed : ee);
  endfunction
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    rst_in = 1'b1;
    req = '0;
    pc = 8'hFF;
    pd = 8'hAA;
    pe = 8'h55;
    repeat (20) @(posedge mclk_in);
    rst_in <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      apb(1'b0, row_a[k], 32'h0, 4'h0);
      chk(rd, 32'h0);
    end
    foreach (row_a[i]) begin
      apb(1'b1, row_a[i], row_d[i], 4'h1);
      chk({24'h0, en_of(row_a[i])}, row_q[i]);
      apb(1'b0, row_a[i], 32'h0, 4'h0);
      chk(rd, row_q[i]);
      chk({31'h0, err}, 32'h0);
    end
    $display("table test done");
    chk({8'h0, lc, ld, le}, {8'h0, pc & 8'h00, pd & 8'h3C, pe & 8'h81});
    apb(1'b1, AD, 32'hFF, 4'h0);
    chk({24'h0, ed}, 32'h3C);
    apb(1'b1, AE + 16'h4, 32'hFF, 4'h1);
    chk({23'h0, err, ee}, 32'h181);
    apb(1'b1, AC + 16'h1, 32'hFF, 4'h1);
    chk({23'h0, err, ec}, 32'h100);
    apb(1'b0, {PIE_IDX_PD_LVL, 2'b00}, 32'h0, 4'h0);
    chk({23'h0, err, rd[7:0]}, {24'h0, pd & 8'h3C});
    $display("awkward test done");
    rst_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    chk({8'h0, ec, ed, ee}, 32'h0);
    chk({8'h0, lc, ld, le}, 32'h0);
    $display("reset test done");
    complete_run;
  end
endmodule
`default_nettype wire
